// ### hw/rficr_regs.v
// Operation
// - each of the eight receivers has its own power-down bit, input 2p is pair p positive, 2p+1 its negative.
// - a power-down bit of 0 keeps its receiver running, 1 powers it down, and all reset to 0.
// - with all eight power-down bits set the whole receiver section goes into deep sleep.
// - positive family 00 is differential, 01/10/11 are the three CMOS ranges, reset 00.
// - the negative family field is ignored while the pair's positive family is 00.
// - negative family 00 disables that receiver, 01/10/11 are the three CMOS ranges, reset 00.
// - family register one holds pair1 at bits 7:4 and pair0 at 3:0, register two pair3 and pair2.
// - each input has a manual-profile enable, 0 automatic at reset, negative at bit 7, positive at bit 3.
// - each input has a 3-bit manual profile picking profile 0 to 7, reset 0.
// - four profile-select registers serve pairs 0 to 3 in ascending address order.
// - a 3-bit threshold, reset 0, makes every reference whose priority is below it a phase master.
// - each profile carries a 3-bit selection priority compared against the threshold.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module rficr_regs (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [23:0] auto_profile,
  input wire [23:0] profile_priority,
  output wire [7:0] rx_power_down,
  output wire rx_deep_sleep,
  output wire [7:0] rx_enable,
  output wire [3:0] pair_differential,
  output wire [15:0] rx_family,
  output wire [23:0] input_profile,
  output wire [7:0] phase_master
);
`include "rficr_map.vh"

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function [3:0] reg_sel;
    input [15:0] addr;
    reg [13:0] idx;
    begin
      idx = addr[15:2];
      if (idx == {2'h0, `RFICR_IDX_POWER_DOWN}) begin
        reg_sel = `RFICR_SEL_POWER_DOWN;
      end else if (idx == {2'h0, `RFICR_IDX_FAMILY_01}) begin
        reg_sel = `RFICR_SEL_FAMILY_01;
      end else if (idx == {2'h0, `RFICR_IDX_FAMILY_23}) begin
        reg_sel = `RFICR_SEL_FAMILY_23;
      end else if (idx == {2'h0, `RFICR_IDX_PROFILE_P0}) begin
        reg_sel = `RFICR_SEL_PROFILE_P0;
      end else if (idx == {2'h0, `RFICR_IDX_PROFILE_P1}) begin
        reg_sel = `RFICR_SEL_PROFILE_P1;
      end else if (idx == {2'h0, `RFICR_IDX_PROFILE_P2}) begin
        reg_sel = `RFICR_SEL_PROFILE_P2;
      end else if (idx == {2'h0, `RFICR_IDX_PROFILE_P3}) begin
        reg_sel = `RFICR_SEL_PROFILE_P3;
      end else if (idx == {2'h0, `RFICR_IDX_THRESHOLD}) begin
        reg_sel = `RFICR_SEL_THRESHOLD;
      end else if (idx == {2'h0, `RFICR_IDX_MASTER_STAT}) begin
        reg_sel = `RFICR_SEL_MASTER_STAT;
      end else if (idx == {2'h0, `RFICR_IDX_SLEEP_STAT}) begin
        reg_sel = `RFICR_SEL_SLEEP_STAT;
      end else begin
        reg_sel = `RFICR_SEL_NONE;
      end
    end
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] power_down_r;
  reg [7:0] family_01_r;
  reg [7:0] family_23_r;
  reg [31:0] profile_sel_r;
  reg [2:0] threshold_r;

  // ----------------------------------------
  // bus state
  // ----------------------------------------
  reg aw_held_r;
  reg w_held_r;
  reg [15:0] awaddr_r;
  reg [7:0] wbyte_r;
  reg wstrb0_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;

  wire aw_take;
  wire w_take;
  wire wr_go;
  wire ar_take;
  wire [3:0] wr_sel;
  wire [3:0] rd_sel;

  // ----------------------------------------
  // derived configuration
  // ----------------------------------------
  wire [15:0] fam_vec;
  wire [3:0] diff_w;
  wire [15:0] fam_eff_w;
  wire [7:0] en_w;
  wire [23:0] prof_w;
  wire [7:0] master_w;
  wire sleep_w;

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  reg [7:0] rx_power_down_r;
  reg rx_deep_sleep_r;
  reg [7:0] rx_enable_r;
  reg [3:0] pair_differential_r;
  reg [15:0] rx_family_r;
  reg [23:0] input_profile_r;
  reg [7:0] phase_master_r;

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  // address and data may arrive in either order; each is held until both
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready = ~w_held_r & ~bvalid_r;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_go = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_sel = reg_sel(awaddr_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 16'h0000;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RFICR_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        // status words and holes answer with an error, nothing changes
        if (wr_sel == `RFICR_SEL_NONE || wr_sel == `RFICR_SEL_MASTER_STAT ||
            wr_sel == `RFICR_SEL_SLEEP_STAT) begin
          bresp_r <= `RFICR_RESP_SLVERR;
        end else begin
          bresp_r <= `RFICR_RESP_OKAY;
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // only byte lane 0 carries data; upper lanes are dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      power_down_r <= `RFICR_RST_POWER_DOWN;
      family_01_r <= `RFICR_RST_FAMILY;
      family_23_r <= `RFICR_RST_FAMILY;
      profile_sel_r <= {4{`RFICR_RST_PROFILE}};
      threshold_r <= `RFICR_RST_THRESHOLD;
    end else if (wr_go && wstrb0_r) begin
      case (wr_sel)
        `RFICR_SEL_POWER_DOWN: begin
          power_down_r <= wbyte_r;
        end
        `RFICR_SEL_FAMILY_01: begin
          family_01_r <= wbyte_r;
        end
        `RFICR_SEL_FAMILY_23: begin
          family_23_r <= wbyte_r;
        end
        `RFICR_SEL_PROFILE_P0: begin
          profile_sel_r[7:0] <= wbyte_r;
        end
        `RFICR_SEL_PROFILE_P1: begin
          profile_sel_r[15:8] <= wbyte_r;
        end
        `RFICR_SEL_PROFILE_P2: begin
          profile_sel_r[23:16] <= wbyte_r;
        end
        `RFICR_SEL_PROFILE_P3: begin
          profile_sel_r[31:24] <= wbyte_r;
        end
        `RFICR_SEL_THRESHOLD: begin
          threshold_r <= wbyte_r[`RFICR_THRESHOLD_MSB:0];
        end
        default: begin
          threshold_r <= threshold_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign s_axi_arready = ~rvalid_r;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rd_sel = reg_sel(s_axi_araddr);

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RFICR_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rresp_r <= `RFICR_RESP_OKAY;
      case (rd_sel)
        `RFICR_SEL_POWER_DOWN: begin
          rdata_r <= {24'h000000, power_down_r};
        end
        `RFICR_SEL_FAMILY_01: begin
          rdata_r <= {24'h000000, family_01_r};
        end
        `RFICR_SEL_FAMILY_23: begin
          rdata_r <= {24'h000000, family_23_r};
        end
        `RFICR_SEL_PROFILE_P0: begin
          rdata_r <= {24'h000000, profile_sel_r[7:0]};
        end
        `RFICR_SEL_PROFILE_P1: begin
          rdata_r <= {24'h000000, profile_sel_r[15:8]};
        end
        `RFICR_SEL_PROFILE_P2: begin
          rdata_r <= {24'h000000, profile_sel_r[23:16]};
        end
        `RFICR_SEL_PROFILE_P3: begin
          rdata_r <= {24'h000000, profile_sel_r[31:24]};
        end
        `RFICR_SEL_THRESHOLD: begin
          rdata_r <= {29'h00000000, threshold_r};
        end
        `RFICR_SEL_MASTER_STAT: begin
          rdata_r <= {24'h000000, phase_master_r};
        end
        `RFICR_SEL_SLEEP_STAT: begin
          rdata_r <= {31'h00000000, rx_deep_sleep_r};
        end
        default: begin
          rdata_r <= 32'h00000000;
          rresp_r <= `RFICR_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ----------------------------------------
  // receiver section
  // ----------------------------------------
  // pair p: positive family at [4p+1:4p], negative at [4p+3:4p+2]
  assign fam_vec = {family_23_r, family_01_r};
  assign sleep_w = &power_down_r;

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp = gp + 1) begin : g_pair
      rficr_pair_decode u_pair (
        .pos_family(fam_vec[4*gp+1:4*gp]),
        .neg_family(fam_vec[4*gp+3:4*gp+2]),
        .pos_power_down(power_down_r[2*gp]),
        .neg_power_down(power_down_r[2*gp+1]),
        .differential(diff_w[gp]),
        .pos_family_eff(fam_eff_w[4*gp+1:4*gp]),
        .neg_family_eff(fam_eff_w[4*gp+3:4*gp+2]),
        .pos_enable(en_w[2*gp]),
        .neg_enable(en_w[2*gp+1])
      );
    end
  endgenerate

  // ----------------------------------------
  // profile association
  // ----------------------------------------
  // input i: enable at bit 4i+3, manual profile at [4i+2:4i]
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_input
      rficr_profile_sel u_prof (
        .manual_enable(profile_sel_r[4*gi+`RFICR_PROF_EN_BIT]),
        .manual_profile(profile_sel_r[4*gi+2:4*gi]),
        .auto_profile(auto_profile[3*gi+2:3*gi]),
        .profile_priority(profile_priority),
        .threshold(threshold_r),
        .profile_eff(prof_w[3*gi+2:3*gi]),
        .phase_master(master_w[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // output flops
  // ----------------------------------------
  // deep sleep overrides every receiver enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_power_down_r <= 8'h00;
      rx_deep_sleep_r <= 1'b0;
      rx_enable_r <= 8'h00;
      pair_differential_r <= 4'h0;
      rx_family_r <= 16'h0000;
      input_profile_r <= 24'h000000;
      phase_master_r <= 8'h00;
    end else begin
      rx_power_down_r <= power_down_r;
      rx_deep_sleep_r <= sleep_w;
      rx_enable_r <= sleep_w ? 8'h00 : en_w;
      pair_differential_r <= diff_w;
      rx_family_r <= fam_eff_w;
      input_profile_r <= prof_w;
      phase_master_r <= master_w;
    end
  end

  assign rx_power_down = rx_power_down_r;
  assign rx_deep_sleep = rx_deep_sleep_r;
  assign rx_enable = rx_enable_r;
  assign pair_differential = pair_differential_r;
  assign rx_family = rx_family_r;
  assign input_profile = input_profile_r;
  assign phase_master = phase_master_r;

endmodule
`default_nettype wire

// ### hw/rficr_map.vh
`ifndef RFICR_MAP_VH
`define RFICR_MAP_VH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define RFICR_IDX_POWER_DOWN 12'h500
`define RFICR_IDX_FAMILY_01 12'h501
`define RFICR_IDX_FAMILY_23 12'h502
`define RFICR_IDX_PROFILE_P0 12'h503
`define RFICR_IDX_PROFILE_P1 12'h504
`define RFICR_IDX_PROFILE_P2 12'h505
`define RFICR_IDX_PROFILE_P3 12'h506
`define RFICR_IDX_THRESHOLD 12'h507
`define RFICR_IDX_MASTER_STAT 12'h508
`define RFICR_IDX_SLEEP_STAT 12'h509

// ----------------------------------------
// register select codes
// ----------------------------------------
`define RFICR_SEL_POWER_DOWN 4'h0
`define RFICR_SEL_FAMILY_01 4'h1
`define RFICR_SEL_FAMILY_23 4'h2
`define RFICR_SEL_PROFILE_P0 4'h3
`define RFICR_SEL_PROFILE_P1 4'h4
`define RFICR_SEL_PROFILE_P2 4'h5
`define RFICR_SEL_PROFILE_P3 4'h6
`define RFICR_SEL_THRESHOLD 4'h7
`define RFICR_SEL_MASTER_STAT 4'h8
`define RFICR_SEL_SLEEP_STAT 4'h9
`define RFICR_SEL_NONE 4'hF

// ----------------------------------------
// reset values
// ----------------------------------------
`define RFICR_RST_POWER_DOWN 8'h00
`define RFICR_RST_FAMILY 8'h00
`define RFICR_RST_PROFILE 8'h00
`define RFICR_RST_THRESHOLD 3'h0

// ----------------------------------------
// field layout and encodings
// ----------------------------------------
`define RFICR_THRESHOLD_MSB 2
`define RFICR_FAM_DIFF 2'h0
`define RFICR_FAM_DISABLED 2'h0
`define RFICR_FAM_CMOS_1V2 2'h1
`define RFICR_FAM_CMOS_1V8 2'h2
`define RFICR_FAM_CMOS_3V0 2'h3
`define RFICR_PROF_EN_BIT 3
`define RFICR_RESP_OKAY 2'h0
`define RFICR_RESP_SLVERR 2'h2

`endif

// ### hw/rficr_pair_decode.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// per-pair receiver configuration decode
// ----------------------------------------
module rficr_pair_decode (
  input wire [1:0] pos_family,
  input wire [1:0] neg_family,
  input wire pos_power_down,
  input wire neg_power_down,
  output wire differential,
  output wire [1:0] pos_family_eff,
  output wire [1:0] neg_family_eff,
  output wire pos_enable,
  output wire neg_enable
);
`include "rficr_map.vh"

  assign differential = (pos_family == `RFICR_FAM_DIFF);
  assign pos_family_eff = pos_family;
  // negative family means nothing while the pair is differential
  assign neg_family_eff = differential ? `RFICR_FAM_DISABLED : neg_family;
  assign pos_enable = ~pos_power_down;
  // in differential mode the negative pin is the pair's minus leg
  assign neg_enable = ~neg_power_down &
                      (differential | (neg_family != `RFICR_FAM_DISABLED));

endmodule
`default_nettype wire

// ### hw/rficr_profile_sel.v
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// per-input profile association and phase-master test
// ----------------------------------------
module rficr_profile_sel (
  input wire manual_enable,
  input wire [2:0] manual_profile,
  input wire [2:0] auto_profile,
  input wire [23:0] profile_priority,
  input wire [2:0] threshold,
  output wire [2:0] profile_eff,
  output wire phase_master
);
`include "rficr_map.vh"

  wire [2:0] prio;

  // manual field is a don't-care while automatic mode is selected
  assign profile_eff = manual_enable ? manual_profile : auto_profile;
  assign prio = profile_priority[profile_eff*3 +: 3];
  assign phase_master = (prio < threshold);

endmodule
`default_nettype wire

// ### tb/rficr_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rficr_regs_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] rx_power_down,
  input wire logic rx_deep_sleep,
  input wire logic [7:0] rx_enable,
  input wire logic [3:0] pair_differential,
  input wire logic [15:0] rx_family
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // outputs lag reset release by two edges
  logic [1:0] settle_r;
  logic df_ok, nf_ok, ne_ok;
  always_ff @(posedge aclk) begin
    if (!aresetn) settle_r <= 2'h0;
    else if (settle_r != 2'h2) settle_r <= settle_r + 2'h1;
  end
  wire settled = settle_r == 2'h2;
  always_comb begin
    df_ok = 1'b1;
    nf_ok = 1'b1;
    ne_ok = 1'b1;
    for (int p = 0; p < 4; p++) begin
      if (pair_differential[p] != (rx_family[4*p +: 2] == 2'h0)) df_ok = 1'b0;
      if (pair_differential[p] && rx_family[4*p+2 +: 2] != 2'h0) nf_ok = 1'b0;
      if (rx_enable[2*p+1] != (!rx_power_down[2*p+1] && (pair_differential[p] || rx_family[4*p+2 +: 2] != 2'h0)))
        ne_ok = 1'b0;
    end
  end
  property p_deep_eq; settled |-> rx_deep_sleep == (&rx_power_down); endproperty
  property p_deep_off; rx_deep_sleep |-> rx_enable == 8'h00; endproperty
  property p_pos_en; settled |-> (rx_enable & 8'h55) == (~rx_power_down & 8'h55); endproperty
  property p_pair_diff; settled |-> df_ok; endproperty
  property p_neg_ignored; settled |-> nf_ok; endproperty
  property p_neg_en; settled |-> ne_ok; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  // both halves are parked for one edge before the response is raised
  property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_deep_eq: assert property (p_deep_eq) else $error("deep sleep differs from all power-down");
  a_deep_off: assert property (p_deep_off) else $error("receiver enabled in deep sleep");
  a_pos_en: assert property (p_pos_en) else $error("positive enable differs from power-down");
  a_pair_diff: assert property (p_pair_diff) else $error("differential flag wrong");
  a_neg_ignored: assert property (p_neg_ignored) else $error("negative family not ignored");
  a_neg_en: assert property (p_neg_en) else $error("negative enable wrong");
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  a_wresp: assert property (p_wresp) else $error("write response late");
  a_rresp: assert property (p_rresp) else $error("read response late");
  c_sleep: cover property ($rose(rx_deep_sleep));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind rficr_regs rficr_regs_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .rx_power_down, .rx_deep_sleep, .rx_enable, .pair_differential, .rx_family);
`default_nettype wire

// ### tb/reference_input_config_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module reference_input_config_regs_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, lfsr_r = 16'h0026;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [23:0] auto_profile = 24'h0, profile_priority = 24'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_deep_sleep;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] rx_power_down, rx_enable, phase_master;
  logic [3:0] pair_differential;
  logic [15:0] rx_family;
  logic [23:0] input_profile;
  logic [7:0] sh [0:7];
  int mismatches = 0;
  int check_count = 0;
  rficr_regs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .auto_profile, .profile_priority, .rx_power_down, .rx_deep_sleep,
    .rx_enable, .pair_differential, .rx_family, .input_profile, .phase_master);
  always #2.5 aclk = ~aclk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic stop_test;
    $display("mismatches=%0d checks=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    check_count++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic axi_write(input logic [11:0] idx, input logic [7:0] d, input logic st, input logic [1:0] er);
    logic a, w, ad, wd;
    logic [1:0] r;
    @(posedge aclk);
    lfsr_r = lfsr_step(lfsr_r);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {lfsr_r, lfsr_r[7:0], d};
    s_axi_wstrb <= {lfsr_r[3:1], st};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd)) begin
      @(negedge aclk);
      a = s_axi_awready;
      w = s_axi_wready;
      @(posedge aclk);
      if (a) begin
        s_axi_awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (w) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    check(r === er, "write response");
  endtask
  task automatic axi_read(input logic [11:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    check(d === {24'h0, ed} && r === er, "read data or response");
  endtask
  task automatic check_outputs;
    logic [7:0] en, pm;
    logic [15:0] fam;
    logic [3:0] df;
    logic [23:0] prof;
    logic [1:0] pf, nf;
    logic [2:0] pr;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    for (int p = 0; p < 4; p++) begin
      pf = sh[1 + p / 2][4 * (p % 2) +: 2];
      nf = sh[1 + p / 2][4 * (p % 2) + 2 +: 2];
      df[p] = pf == 2'h0;
      fam[4*p +: 4] = {df[p] ? 2'h0 : nf, pf};
      en[2*p] = !sh[0][2*p];
      en[2*p+1] = !sh[0][2*p+1] && (df[p] || nf != 2'h0);
      for (int s = 0; s < 2; s++) begin
        pr = sh[3+p][4*s+3] ? sh[3+p][4*s +: 3] : auto_profile[6*p + 3*s +: 3];
        prof[6*p + 3*s +: 3] = pr;
        pm[2*p+s] = profile_priority[3*pr +: 3] < sh[7][2:0];
      end
    end
    check(rx_power_down === sh[0], "power-down image");
    check(rx_deep_sleep === (&sh[0]), "deep sleep");
    check(rx_enable === ((&sh[0]) ? 8'h00 : en), "receiver enables");
    check(pair_differential === df && rx_family === fam, "families");
    check(input_profile === prof, "profiles");
    check(phase_master === pm, "phase master");
    axi_read(12'h508, pm, 2'h0);
    axi_read(12'h509, {7'h0, &sh[0]}, 2'h0);
  endtask
  // random profile inputs, then write, read back and compare outputs
  task automatic put(input int r, input logic [7:0] d);
    @(posedge aclk);
    lfsr_r = lfsr_step(lfsr_r);
    auto_profile <= {lfsr_r, lfsr_r[15:8]};
    lfsr_r = lfsr_step(lfsr_r);
    profile_priority <= {lfsr_r[7:0], lfsr_r};
    axi_write(12'h500 + r[11:0], d, 1'b1, 2'h0);
    sh[r] = (r == 7) ? {5'h0, d[2:0]} : d;
    axi_read(12'h500 + r[11:0], sh[r], 2'h0);
    check_outputs;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    #100000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) sh[i] = 8'h00;
    check_outputs;
    for (int i = 0; i < 8; i++) axi_read(12'h500 + i[11:0], 8'h00, 2'h0);
    axi_read(12'h50A, 8'h00, 2'h2);
    axi_write(12'h508, 8'hFF, 1'b1, 2'h2);
    for (int c = 0; c < 4; c++) begin
      put(1, {4{c[1:0]}});
      put(2, {c[1:0], 2'h0, 2'h3, c[1:0]});
    end
    put(0, 8'hFF);
    for (int b = 0; b < 8; b++) put(0, 8'h01 << b);
    axi_write(12'h500, 8'hAA, 1'b0, 2'h0);
    check_outputs;
    put(7, 8'hFF);
    for (int n = 0; n < 40; n++) begin
      lfsr_r = lfsr_step(lfsr_r);
      put(int'(lfsr_r[2:0]), lfsr_r[15:8]);
    end
    // mid-run reset must bring every register back to its reset value
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) sh[i] = 8'h00;
    check_outputs;
    put(7, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire
